// *** shared/fpuie_pkg.sv ***
// Package for the floating-point underflow and inexact decision unit
package fpuie_pkg;

  // Destination formats
  typedef enum logic [1:0] {
    FMT_REAL,
    FMT_LONG,
    FMT_EXT,
    FMT_INT
  } fpuie_fmt_e;

  // Fault subtypes
  typedef enum logic [1:0] {
    SUB_NONE,
    SUB_OVERFLOW,
    SUB_UNDERFLOW,
    SUB_INEXACT
  } fpuie_sub_e;

  // Exponent thresholds, unbiased
  localparam logic signed [19:0] EMIN_REAL = -20'sd126;
  localparam logic signed [19:0] EMIN_LONG = -20'sd1022;
  localparam logic signed [19:0] EMIN_EXT  = -20'sd16382;
  localparam logic signed [19:0] EMAX_EXT  = 20'sd16383;
  localparam logic signed [19:0] BIAS_ADJ  = 20'sd24576;
  localparam logic [14:0]        EXT_BIAS  = 15'h3fff;

  // Fraction bits cleared per destination precision
  localparam int ZERO_BITS_REAL = 40;
  localparam int ZERO_BITS_LONG = 11;

  // Fault flags byte: bias-adjust position
  localparam int FFLAG_BIAS_BIT = 1;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STAT   = 8'h04;
  localparam logic [7:0] OFS_IMASK  = 8'h08;
  localparam logic [7:0] OFS_REC_LO = 8'h0c;
  localparam logic [7:0] OFS_REC_HI = 8'h10;
  localparam logic [7:0] OFS_FFLAGS = 8'h14;

  // Control register fields (flags low, masks high)
  localparam int CTL_OVF_FLAG = 0;
  localparam int CTL_UNF_FLAG = 1;
  localparam int CTL_INX_FLAG = 2;
  localparam int CTL_OVF_MASK = 8;
  localparam int CTL_UNF_MASK = 9;
  localparam int CTL_INX_MASK = 10;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;

  // Interrupt status bits
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_DONE  = 1;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// *** core/fpuie_unit.sv ***
// Underflow and inexact exception decision unit with AXI4-Lite registers
`timescale 1ns/1ps
// Behaviour
// - Massive scale overflow records signed infinity
// - Float-to-integer conversion never flags overflow
// - Underflow when exponent below destination minimum
// - Masked exact denormal: store, no flag
// - Masked inexact denormal: set underflow, continue
// - Unmasked underflow: no store, record extended
// - Record exponent beyond extended range bias adjusted, flag bit
// - Massive scale underflow records signed zero
// - Inexact on rounding change or masked overflow
// - Masked inexact: store rounded, set flag
// - Unmasked sole inexact: store, then fault
// - Unmasked inexact with ovf/unf: record, fault
// - Tininess after rounding; accuracy loss inexact
// - Masked underflow flag then inexact fault
// - Flags sticky; only software writes or reset clear
// - Unmasked exception records and raises fault
module fpuie_unit
  import fpuie_pkg::*;
(
  // Clock and reset
  input  wire  logic                  aclk,
  input  wire  logic                  aresetn,
  // Result from datapath
  input  wire  logic                  res_valid,
  input  wire  fpuie_pkg::fpuie_fmt_e res_fmt,
  input  wire  logic                  res_sign,
  input  wire  logic signed [19:0]    res_exp,
  input  wire  logic [63:0]           res_sig,
  input  wire  logic                  res_inexact,
  input  wire  logic                  res_ovf,
  input  wire  logic                  res_is_scale,
  input  wire  logic                  res_massive,
  input  wire  logic                  res_denorm_exact,
  // Outcome to datapath
  output logic                        dest_we,
  output logic                        dest_denorm,
  // Fault dispatch
  output logic                        fault_req,
  output fpuie_pkg::fpuie_sub_e       fault_sub,
  output logic                        fault_bias_adj,
  output logic [79:0]                 fault_rec,
  // AXI4-Lite slave
  input  wire  logic [7:0]            s_axi_awaddr,
  input  wire  logic                  s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire  logic [31:0]           s_axi_wdata,
  input  wire  logic [3:0]            s_axi_wstrb,
  input  wire  logic                  s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire  logic                  s_axi_bready,
  input  wire  logic [7:0]            s_axi_araddr,
  input  wire  logic                  s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire  logic                  s_axi_rready,
  // Interrupt
  output logic                        irq
);

  typedef struct packed {
    logic [31:0]  ctrl;
    logic [1:0]   istat;
    logic [1:0]   imask;
    logic         aw_got;
    logic [7:0]   aw_addr;
    logic         w_got;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
    logic         dest_we;
    logic         dest_denorm;
    logic         fault_req;
    fpuie_sub_e   fault_sub;
    logic         fault_bias;
    logic [79:0]  fault_rec;
  } fpuie_state_s;

  fpuie_state_s s_q, s_d;

  // Threshold by destination format
  function automatic logic signed [19:0] emin_of(input fpuie_fmt_e f);
    unique case (f)
      FMT_REAL: emin_of = EMIN_REAL;
      FMT_LONG: emin_of = EMIN_LONG;
      default:  emin_of = EMIN_EXT;
    endcase
  endfunction

  // Byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction

  // Extended-real record build with bias adjust
  function automatic logic [80:0] build_rec(input logic sg, input logic signed [19:0] e,
                                            input logic [63:0] m, input fpuie_fmt_e f,
                                            input logic massive, input logic big);
    logic signed [19:0] ea;
    logic [63:0]        mm;
    logic               adj;
    ea  = e;
    mm  = m;
    adj = 1'b0;
    if (f == FMT_REAL) begin
      mm[ZERO_BITS_REAL-1:0] = '0;
    end else if (f == FMT_LONG) begin
      mm[ZERO_BITS_LONG-1:0] = '0;
    end
    if (massive) begin
      build_rec = big ? {1'b0, sg, 15'h7fff, 64'h8000_0000_0000_0000}
                      : {1'b0, sg, 15'h0000, 64'h0};
    end else begin
      if (e < EMIN_EXT) begin
        ea  = e + BIAS_ADJ;
        adj = 1'b1;
      end else if (e > EMAX_EXT) begin
        ea  = e - BIAS_ADJ;
        adj = 1'b1;
      end
      build_rec = {adj, sg, 15'(ea + 20'(EXT_BIAS)), mm};
    end
  endfunction

  logic        tiny;
  logic        ovf_ok;
  logic        inx;
  logic        m_ovf;
  logic        m_unf;
  logic        m_inx;
  logic [80:0] rec;
  logic        wr_go;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic        wr_ok;
  logic [2:0]  set_flags;
  logic        evt_fault;

  always_comb begin
    m_ovf  = s_q.ctrl[CTL_OVF_MASK];
    m_unf  = s_q.ctrl[CTL_UNF_MASK];
    m_inx  = s_q.ctrl[CTL_INX_MASK];
    // Exponent after rounding compared to destination minimum
    tiny   = (res_fmt != FMT_INT) && (res_exp < emin_of(res_fmt));
    ovf_ok = res_ovf && (res_fmt != FMT_INT);
    inx    = res_inexact || (ovf_ok && m_ovf);
    rec    = build_rec(res_sign, res_exp, res_sig, res_fmt, res_massive && res_is_scale,
                       ovf_ok);
    rd_ok  = 1'b1;
    rd_val = 32'h0;
    unique case (s_axi_araddr)
      OFS_CTRL:   rd_val = s_q.ctrl;
      OFS_STAT:   rd_val = {30'h0, s_q.istat};
      OFS_IMASK:  rd_val = {30'h0, s_q.imask};
      OFS_REC_LO: rd_val = s_q.fault_rec[31:0];
      OFS_REC_HI: rd_val = s_q.fault_rec[63:32];
      OFS_FFLAGS: rd_val = {16'h0, s_q.fault_rec[79:64]} |
                           (32'(s_q.fault_bias) << (16 + FFLAG_BIAS_BIT));
      default:    rd_ok  = 1'b0;
    endcase
  end

  always_comb begin
    s_d         = s_q;
    set_flags   = 3'b000;
    evt_fault   = 1'b0;
    s_d.dest_we = 1'b0;
    s_d.dest_denorm = 1'b0;
    s_d.fault_req   = 1'b0;
    if (res_valid) begin
      if (tiny) begin
        if (!m_unf) begin
          s_d.fault_req = 1'b1;
          s_d.fault_sub = SUB_UNDERFLOW;
        end else if (res_denorm_exact) begin
          s_d.dest_we     = 1'b1;
          s_d.dest_denorm = 1'b1;
        end else begin
          set_flags[CTL_UNF_FLAG] = 1'b1;
          if (!m_inx) begin
            s_d.fault_req = 1'b1;
            s_d.fault_sub = SUB_INEXACT;
          end else begin
            set_flags[CTL_INX_FLAG] = 1'b1;
            s_d.dest_we     = 1'b1;
            s_d.dest_denorm = 1'b1;
          end
        end
      end else if (ovf_ok && !m_ovf) begin
        s_d.fault_req = 1'b1;
        s_d.fault_sub = SUB_OVERFLOW;
      end else begin
        if (ovf_ok) begin
          set_flags[CTL_OVF_FLAG] = 1'b1;
        end
        if (inx && !m_inx) begin
          s_d.fault_req = 1'b1;
          s_d.fault_sub = SUB_INEXACT;
          s_d.dest_we   = !ovf_ok;
        end else begin
          if (inx) begin
            set_flags[CTL_INX_FLAG] = 1'b1;
          end
          s_d.dest_we = 1'b1;
        end
      end
      if (s_d.fault_req) begin
        s_d.fault_rec  = rec[79:0];
        s_d.fault_bias = rec[80];
        evt_fault      = 1'b1;
      end
    end

    // Write channel capture
    if (s_axi_awvalid && !s_q.aw_got) begin
      s_d.aw_got  = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_got) begin
      s_d.w_got  = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    wr_go = s_q.aw_got && s_q.w_got && !s_q.bvalid;
    wr_ok = 1'b1;
    if (wr_go) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      unique case (s_q.aw_addr)
        OFS_CTRL:  s_d.ctrl  = merge(s_q.ctrl, s_q.w_data, s_q.w_strb);
        OFS_STAT:  s_d.istat = s_q.istat & ~(s_q.w_data[1:0] & {2{s_q.w_strb[0]}});
        OFS_IMASK: s_d.imask = s_q.w_strb[0] ? s_q.w_data[1:0] : s_q.imask;
        OFS_REC_LO, OFS_REC_HI, OFS_FFLAGS: wr_ok = 1'b1;
        default:   wr_ok = 1'b0;
      endcase
      s_d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // Hardware flag sets win over software writes
    s_d.ctrl[2:0] = s_d.ctrl[2:0] | set_flags;
    s_d.istat[IRQ_FAULT] = s_d.istat[IRQ_FAULT] | evt_fault;
    s_d.istat[IRQ_DONE]  = s_d.istat[IRQ_DONE] | (res_valid && !evt_fault);

    // Read channel
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_val;
      s_d.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q      <= '0;
      s_q.ctrl <= CTL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready  = !s_q.aw_got;
  assign s_axi_wready   = !s_q.w_got;
  assign s_axi_bvalid   = s_q.bvalid;
  assign s_axi_bresp    = s_q.bresp;
  assign s_axi_arready  = !s_q.rvalid;
  assign s_axi_rvalid   = s_q.rvalid;
  assign s_axi_rdata    = s_q.rdata;
  assign s_axi_rresp    = s_q.rresp;
  assign dest_we        = s_q.dest_we;
  assign dest_denorm    = s_q.dest_denorm;
  assign fault_req      = s_q.fault_req;
  assign fault_sub      = s_q.fault_sub;
  assign fault_bias_adj = s_q.fault_bias;
  assign fault_rec      = s_q.fault_rec;
  assign irq            = |(s_q.istat & s_q.imask);

endmodule

// *** dv/fpuie_dispatch.sv ***
// Fault-dispatch partner: counts fault requests taken
`timescale 1ns/1ps
module fpuie_dispatch
  import fpuie_pkg::*;
(
  // Clock and reset
  input  logic       aclk,
  input  logic       aresetn,
  // Fault request
  input  logic       fault_req,
  input  fpuie_sub_e fault_sub,
  // Count seen
  output logic [7:0] taken_q
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      taken_q <= 8'h0;
    end else if (fault_req && fault_sub != SUB_NONE) begin
      taken_q <= taken_q + 8'h1;
    end
  end
endmodule

// *** dv/fpuie_unit_asserts.sv ***
// Port checker for the exception decision unit
`timescale 1ns/1ps
module fpuie_unit_asserts
  import fpuie_pkg::*;
(
  // Clock and reset
  input logic               aclk,
  input logic               aresetn,
  // Result in
  input logic               res_valid,
  input fpuie_fmt_e         res_fmt,
  input logic               res_sign,
  input logic signed [19:0] res_exp,
  input logic               res_ovf,
  input logic               res_is_scale,
  input logic               res_massive,
  // Outcome
  input logic               dest_we,
  input logic               fault_req,
  input fpuie_sub_e         fault_sub,
  input logic               fault_bias_adj,
  input logic [79:0]        fault_rec,
  // Read channel
  input logic               s_axi_arvalid,
  input logic               s_axi_arready,
  input logic               s_axi_rvalid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_mass(logic o);
    res_valid && res_is_scale && res_massive && res_ovf == o ##1 fault_req;
  endsequence
  sequence s_unf(logic c);
    res_valid && c ##1 fault_req && fault_sub == SUB_UNDERFLOW;
  endsequence
  a_we_cause: assert property (dest_we |-> $past(res_valid))
    else $error("store without a result");
  a_fault_cause: assert property (fault_req |-> $past(res_valid))
    else $error("fault without a result");
  a_int_no_ovf: assert property (res_valid && res_fmt == FMT_INT
    |=> !(fault_req && fault_sub == SUB_OVERFLOW)) else $error("overflow on integer");
  a_mass_inf: assert property (s_mass(1'h1) |-> fault_rec[78:64] == 15'h7fff
    && fault_rec[79] == $past(res_sign)) else $error("massive overflow record");
  a_mass_zero: assert property (s_mass(1'h0) |-> fault_rec[78:0] == 79'h0
    && fault_rec[79] == $past(res_sign)) else $error("massive underflow record");
  a_real_low0: assert property (s_unf(res_fmt == FMT_REAL)
    |-> fault_rec[39:0] == 40'h0) else $error("real record low bits");
  a_bias_flag: assert property (s_unf(!res_is_scale)
    |-> fault_bias_adj == ($past(res_exp) < EMIN_EXT)) else $error("bias flag");
  a_rec_held: assert property (!fault_req |-> $stable(fault_rec) && $stable(fault_sub))
    else $error("fault record moved");
  a_read_ans: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_unf_nostore: assert property (s_unf(1'h1) |-> !dest_we)
    else $error("store on unmasked underflow");
  a_long_low0: assert property (s_unf(res_fmt == FMT_LONG)
    |-> fault_rec[10:0] == 11'h0) else $error("long record low bits");
  a_sub_given: assert property (fault_req |-> fault_sub != SUB_NONE)
    else $error("fault without subtype");
endmodule
bind fpuie_unit fpuie_unit_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
  .res_valid(res_valid), .res_fmt(res_fmt), .res_sign(res_sign), .res_exp(res_exp),
  .res_ovf(res_ovf), .res_is_scale(res_is_scale), .res_massive(res_massive),
  .dest_we(dest_we), .fault_req(fault_req), .fault_sub(fault_sub),
  .fault_bias_adj(fault_bias_adj), .fault_rec(fault_rec), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

// *** dv/fpuie_unit_tb_top.sv ***
// Testbench for the exception decision unit
`timescale 1ns/1ps
module fpuie_unit_tb_top;
  import fpuie_pkg::*;
  typedef struct packed {
    logic [2:0] m; fpuie_fmt_e f; logic signed [19:0] e;
    logic [2:0] c; logic [1:0] w; fpuie_sub_e s; logic [2:0] g;
  } fpuie_row_s;
  // Masks, format, exponent, {inx,ovf,exact}, {we,fault}, subtype, flags
  fpuie_row_s rows [11] = '{
    '{3'h2, FMT_REAL, -20'sh7f, 3'h1, 2'h2, SUB_NONE, 3'h0},
    '{3'h6, FMT_REAL, -20'sh7f, 3'h4, 2'h2, SUB_NONE, 3'h6},
    '{3'h2, FMT_REAL, -20'sh7f, 3'h4, 2'h1, SUB_INEXACT, 3'h2},
    '{3'h0, FMT_REAL, -20'sh7f, 3'h1, 2'h1, SUB_UNDERFLOW, 3'h0},
    '{3'h0, FMT_REAL, -20'sh7e, 3'h1, 2'h2, SUB_NONE, 3'h0},
    '{3'h4, FMT_REAL, 20'sh0, 3'h4, 2'h2, SUB_NONE, 3'h4},
    '{3'h0, FMT_REAL, 20'sh0, 3'h4, 2'h3, SUB_INEXACT, 3'h0},
    '{3'h5, FMT_REAL, 20'sh0, 3'h3, 2'h2, SUB_NONE, 3'h5},
    '{3'h1, FMT_REAL, 20'sh0, 3'h3, 2'h1, SUB_INEXACT, 3'h1},
    '{3'h5, FMT_INT, 20'sh0, 3'h3, 2'h2, SUB_NONE, 3'h0},
    '{3'h0, FMT_LONG, -20'sh3ff, 3'h1, 2'h1, SUB_UNDERFLOW, 3'h0}};
  logic aclk = '0, aresetn = '0, res_valid = '0, res_sign = '0, res_inexact = '0;
  logic res_ovf = '0, res_is_scale = '0, res_massive = '0, res_denorm_exact = '0;
  fpuie_fmt_e res_fmt = FMT_REAL;
  logic signed [19:0] res_exp = '0;
  logic [63:0] res_sig = 64'hc000_0000_0000_0fff;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, taken_q;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_q;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, dest_we, dest_denorm, fault_req, irq;
  logic fault_bias_adj, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  fpuie_sub_e fault_sub;
  logic [79:0] fault_rec;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int n_fail = 0, samples_checked = 0, cyc = 0, n_exp = 0;
  fpuie_unit dut (.aclk, .aresetn, .res_valid, .res_fmt, .res_sign, .res_exp,
    .res_sig, .res_inexact, .res_ovf, .res_is_scale, .res_massive,
    .res_denorm_exact, .dest_we, .dest_denorm, .fault_req, .fault_sub, .fault_bias_adj,
    .fault_rec, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
  fpuie_dispatch u_disp (.aclk, .aresetn, .fault_req, .fault_sub, .taken_q);
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    rsp = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    rd_q = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task automatic send(input fpuie_fmt_e f, input logic [19:0] e, input logic [2:0] c,
                      input logic [2:0] x);
    @(posedge aclk);
    res_fmt <= f;
    res_exp <= e;
    {res_inexact, res_ovf, res_denorm_exact} <= c;
    {res_sign, res_is_scale, res_massive} <= x;
    res_valid <= 1'h1;
    @(posedge aclk);
    res_valid <= 1'h0;
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rd(OFS_CTRL);
    chk(rd_q, CTL_RESET);
    rd(8'h18);
    chk(rsp, RESP_SLVERR);
    foreach (rows[k]) begin
      wr(OFS_CTRL, {21'h0, rows[k].m, 8'h0});
      send(rows[k].f, rows[k].e, rows[k].c, 3'h0);
      chk({dest_we, fault_req}, rows[k].w);
      chk(dest_denorm, rows[k].w[1] && ($signed(rows[k].e) < EMIN_REAL));
      if (rows[k].w[0]) begin
        n_exp++;
        chk(fault_sub, rows[k].s);
      end
      rd(OFS_CTRL);
      chk(rd_q[2:0], rows[k].g);
    end
    wr(OFS_CTRL, 32'h400);
    send(FMT_REAL, 20'h0, 3'h4, 3'h0);
    send(FMT_REAL, 20'h0, 3'h1, 3'h0);
    rd(OFS_CTRL);
    chk(rd_q, 32'h404);
    wr(OFS_CTRL, 32'h400);
    rd(OFS_CTRL);
    chk(rd_q, 32'h400);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_IMASK, 32'h1);
    send(FMT_REAL, -20'sh7f, 3'h1, 3'h0);
    n_exp++;
    chk(fault_rec[63:0], 64'hc000_0000_0000_0000);
    send(FMT_EXT, -20'sh3fff, 3'h1, 3'h0);
    n_exp++;
    chk(fault_rec[78:64], 15'h6000);
    chk(fault_rec[63:0], 64'hc000_0000_0000_0fff);
    rd(OFS_FFLAGS);
    chk(rd_q[17], 1'h1);
    chk(irq, 1'h1);
    wr(OFS_STAT, 32'h3);
    chk(irq, 1'h0);
    wr(OFS_IMASK, 32'h0);
    send(FMT_LONG, 20'sh7ffff, 3'h2, 3'h7);
    chk(fault_rec[79:64], 16'hffff);
    send(FMT_LONG, -20'sh7ffff, 3'h0, 3'h7);
    chk(fault_rec, {1'h1, 79'h0});
    n_exp += 2;
    rd(OFS_STAT);
    chk(irq, 1'h0);
    wr(OFS_IMASK, 32'h1);
    rd(OFS_STAT);
    chk(irq, 1'h1);
    chk(taken_q, n_exp[7:0]);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rd(OFS_STAT);
    chk(rd_q, 32'h0);
    close_out();
  end
endmodule
